/* File: include/fsps_pkg.sv */
package fsps_pkg;

    // Command codes held in the command register
    localparam logic [7:0] CMD_NONE  = 8'h00;
    localparam logic [7:0] CMD_ERASE = 8'h03;
    localparam logic [7:0] CMD_BLANK = 8'h04;
    localparam logic [7:0] CMD_WRITE = 8'h05;

    // Key values and the content of an erased cell
    localparam logic [7:0] PROTECT_KEY = 8'hA5;
    localparam logic [7:0] WDT_KEY     = 8'hAC;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;

    // Register byte offsets on the APB
    localparam logic [7:0] OFF_CMD      = 8'h00;
    localparam logic [7:0] OFF_APH      = 8'h04;
    localparam logic [7:0] OFF_APL      = 8'h08;
    localparam logic [7:0] OFF_ACH      = 8'h0C;
    localparam logic [7:0] OFF_ACL      = 8'h10;
    localparam logic [7:0] OFF_WBUF     = 8'h14;
    localparam logic [7:0] OFF_STATUS   = 8'h18;
    localparam logic [7:0] OFF_PCMD     = 8'h1C;
    localparam logic [7:0] OFF_MODE     = 8'h20;
    localparam logic [7:0] OFF_WATCHDOG_ENABLE_REG     = 8'h24;
    localparam logic [7:0] OFF_BOUNDARY = 8'h28;
    localparam logic [7:0] OFF_IRQ_ST   = 8'h2C;
    localparam logic [7:0] OFF_IRQ_EN   = 8'h30;
    localparam logic [7:0] OFF_IRQ_CLR  = 8'h34;
    localparam logic [7:0] OFF_STATE    = 8'h38;

    // Flash status register bit positions
    localparam int ST_MODE_ERR = 0;
    localparam int ST_VERIFY   = 1;
    localparam int ST_PROTECT  = 2;

    // Interrupt status bit positions
    localparam int IRQ_DONE = 0;
    localparam int IRQ_ERR  = 1;
    localparam int IRQ_MODE = 2;

    // Reset values
    localparam logic [7:0] RST_BYTE     = 8'h00;
    localparam logic [7:0] RST_BOUNDARY = 8'h00;

    // Operations offered by the flash array port
    typedef enum logic [1:0] {
        FSPS_OP_READ,
        FSPS_OP_PROG,
        FSPS_OP_ERASE
    } fsps_op_t;

    // Sequencer states
    typedef enum logic [1:0] {
        FSPS_IDLE,
        FSPS_MODIFY,
        FSPS_CHECK
    } fsps_state_t;

endpackage

/* File: rtl/fsps_sequencer.sv */
`timescale 1ns/1ns
module fsps_sequencer (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        cpu_halt_req,
    output logic             cpu_resume,
    output logic             cpu_stalled,
    output logic             wdt_restart,
    output logic             irq,
    output logic             fl_req,
    output logic      [1:0]  fl_op,
    output logic      [15:0] fl_addr,
    output logic      [7:0]  fl_wdata,
    input  wire logic        fl_ack,
    input  wire logic [7:0]  fl_rdata
);

    ////////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        fsps_pkg::fsps_state_t state;
        logic [7:0]            cmd;
        logic [7:0]            aph;
        logic [7:0]            apl;
        logic [7:0]            ach;
        logic [7:0]            acl;
        logic [7:0]            wbuf;
        logic [2:0]            status;
        logic                  armed;
        logic [1:0]            mode_step;
        logic [7:0]            mode_val;
        logic                  mode_on;
        logic [7:0]            boundary;
        logic [2:0]            irq_st;
        logic [2:0]            irq_en;
        logic                  irq;
        logic                  wdt;
        logic                  resume;
        logic                  stalled;
        logic                  fl_req;
        logic [1:0]            fl_op;
        logic [15:0]           fl_addr;
        logic [7:0]            fl_wdata;
        logic                  pready;
        logic                  pslverr;
        logic [31:0]           prdata;
    } fsps_regs_t;

    fsps_regs_t s_ff;
    fsps_regs_t nxt_s;

    // Address decode shared by read and write paths
    function automatic logic fsps_mapped(input logic [7:0] a);
        fsps_mapped = (a <= fsps_pkg::OFF_STATE) && (a[1:0] == 2'b00);
    endfunction

    // Only these codes start work; anything else resumes at once
    function automatic logic fsps_cmd_known(input logic [7:0] c);
        fsps_cmd_known = (c == fsps_pkg::CMD_ERASE) || (c == fsps_pkg::CMD_BLANK)
                         || (c == fsps_pkg::CMD_WRITE);
    endfunction

    logic       acc;
    logic       wr;
    logic       halt_go;
    logic       prot_hit;
    logic       last_addr;
    logic [2:0] st_set;
    logic [2:0] irq_set;
    logic [7:0] wb;

    assign acc       = psel & penable;
    assign wr        = acc & pwrite & s_ff.pready;
    assign wb        = pwdata[7:0];
    assign halt_go   = cpu_halt_req && (s_ff.state == fsps_pkg::FSPS_IDLE) && !s_ff.stalled;
    assign prot_hit  = (s_ff.cmd != fsps_pkg::CMD_BLANK) && (s_ff.aph < s_ff.boundary);
    // Block erase sweeps to the end of the block, since software leaves both low registers
    // at zero for it; the low compare only bounds a blank check
    assign last_addr = (s_ff.cmd == fsps_pkg::CMD_WRITE)
                       || ((s_ff.cmd == fsps_pkg::CMD_ERASE) ? (&s_ff.fl_addr[7:0])
                                                             : (s_ff.fl_addr[7:0] == s_ff.acl));

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    // One process builds the whole next state; hardware sets win over clears
    always_comb begin
        nxt_s         = s_ff;
        st_set        = 3'h0;
        irq_set       = 3'h0;
        nxt_s.wdt     = 1'b0;
        nxt_s.resume  = 1'b0;
        nxt_s.pslverr = 1'b0;
        nxt_s.pready  = acc & ~s_ff.pready;

        // Read data is captured in the wait cycle so it stands on the ready edge
        if (acc && !s_ff.pready && !pwrite) begin
            nxt_s.pslverr = !fsps_mapped(paddr);
            case (paddr)
                fsps_pkg::OFF_CMD:      nxt_s.prdata = {24'h0, s_ff.cmd};
                fsps_pkg::OFF_APH:      nxt_s.prdata = {24'h0, s_ff.aph};
                fsps_pkg::OFF_APL:      nxt_s.prdata = {24'h0, s_ff.apl};
                fsps_pkg::OFF_ACH:      nxt_s.prdata = {24'h0, s_ff.ach};
                fsps_pkg::OFF_ACL:      nxt_s.prdata = {24'h0, s_ff.acl};
                fsps_pkg::OFF_WBUF:     nxt_s.prdata = {24'h0, s_ff.wbuf};
                fsps_pkg::OFF_STATUS:   nxt_s.prdata = {29'h0, s_ff.status};
                fsps_pkg::OFF_MODE:     nxt_s.prdata = {31'h0, s_ff.mode_on};
                fsps_pkg::OFF_BOUNDARY: nxt_s.prdata = {24'h0, s_ff.boundary};
                fsps_pkg::OFF_IRQ_ST:   nxt_s.prdata = {29'h0, s_ff.irq_st};
                fsps_pkg::OFF_IRQ_EN:   nxt_s.prdata = {29'h0, s_ff.irq_en};
                fsps_pkg::OFF_STATE:    nxt_s.prdata = {30'h0, s_ff.stalled, s_ff.mode_on};
                default:                nxt_s.prdata = 32'h0;
            endcase
        end
        if (acc && !s_ff.pready && pwrite) begin
            nxt_s.pslverr = !fsps_mapped(paddr);
        end

        // Register writes; parameters are frozen while a command runs
        if (wr && !s_ff.stalled) begin
            case (paddr)
                fsps_pkg::OFF_CMD:      nxt_s.cmd = wb;
                fsps_pkg::OFF_APH:      nxt_s.aph = wb;
                fsps_pkg::OFF_APL:      nxt_s.apl = wb;
                fsps_pkg::OFF_ACH:      nxt_s.ach = wb;
                fsps_pkg::OFF_ACL:      nxt_s.acl = wb;
                fsps_pkg::OFF_WBUF:     nxt_s.wbuf = wb;
                fsps_pkg::OFF_STATUS:   nxt_s.status = wb[2:0];
                fsps_pkg::OFF_BOUNDARY: nxt_s.boundary = wb;
                fsps_pkg::OFF_IRQ_EN:   nxt_s.irq_en = wb[2:0];
                fsps_pkg::OFF_IRQ_CLR:  nxt_s.irq_st = s_ff.irq_st & ~wb[2:0];
                fsps_pkg::OFF_WATCHDOG_ENABLE_REG:     nxt_s.wdt = (wb == fsps_pkg::WDT_KEY);
                default: ;
            endcase
        end

        // Protected mode change: key, value, inverse, value again
        if (wr && !s_ff.stalled) begin
            if (paddr == fsps_pkg::OFF_PCMD) begin
                nxt_s.armed     = (wb == fsps_pkg::PROTECT_KEY);
                nxt_s.mode_step = 2'd0;
            end else if (paddr == fsps_pkg::OFF_MODE) begin
                nxt_s.mode_step = 2'd0;
                if (!s_ff.armed) begin
                    st_set[fsps_pkg::ST_MODE_ERR] = 1'b1;
                end else if (s_ff.mode_step == 2'd0) begin
                    nxt_s.mode_val  = wb;
                    nxt_s.mode_step = 2'd1;
                end else if (s_ff.mode_step == 2'd1 && wb == ~s_ff.mode_val) begin
                    nxt_s.mode_step = 2'd2;
                end else if (s_ff.mode_step == 2'd2 && wb == s_ff.mode_val) begin
                    nxt_s.mode_on = s_ff.mode_val[0];
                    nxt_s.armed   = 1'b0;
                end else begin
                    st_set[fsps_pkg::ST_MODE_ERR] = 1'b1;
                    nxt_s.armed = 1'b0;
                end
            end else if (s_ff.armed && paddr != fsps_pkg::OFF_STATUS) begin
                // A stray write breaks the sequence, so software must repeat it
                st_set[fsps_pkg::ST_MODE_ERR] = 1'b1;
                nxt_s.armed = 1'b0;
            end
        end

        // Sequencer
        case (s_ff.state)
            fsps_pkg::FSPS_IDLE: begin
                if (halt_go) begin
                    if (!s_ff.mode_on || !fsps_cmd_known(s_ff.cmd)) begin
                        nxt_s.resume = 1'b1;
                    end else if (prot_hit) begin
                        st_set[fsps_pkg::ST_PROTECT] = 1'b1;
                        nxt_s.resume = 1'b1;
                    end else begin
                        nxt_s.stalled = 1'b1;
                        nxt_s.fl_addr = {s_ff.aph, s_ff.apl};
                        nxt_s.state   = (s_ff.cmd == fsps_pkg::CMD_BLANK) ?
                                        fsps_pkg::FSPS_CHECK : fsps_pkg::FSPS_MODIFY;
                    end
                end
            end
            fsps_pkg::FSPS_MODIFY: begin
                // Erase or program the addressed cell, then read it back
                nxt_s.fl_op    = (s_ff.cmd == fsps_pkg::CMD_ERASE) ?
                                 fsps_pkg::FSPS_OP_ERASE : fsps_pkg::FSPS_OP_PROG;
                nxt_s.fl_wdata = s_ff.wbuf;
                nxt_s.fl_req   = 1'b1;
                if (s_ff.fl_req && fl_ack) begin
                    nxt_s.fl_req = 1'b0;
                    nxt_s.state  = fsps_pkg::FSPS_CHECK;
                end
            end
            fsps_pkg::FSPS_CHECK: begin
                nxt_s.fl_op  = fsps_pkg::FSPS_OP_READ;
                nxt_s.fl_req = 1'b1;
                if (s_ff.fl_req && fl_ack) begin
                    nxt_s.fl_req = 1'b0;
                    if (fl_rdata != ((s_ff.cmd == fsps_pkg::CMD_WRITE) ?
                                     s_ff.wbuf : fsps_pkg::ERASED_BYTE)) begin
                        // First mismatch ends the command; no use going on
                        st_set[fsps_pkg::ST_VERIFY] = 1'b1;
                        nxt_s.state   = fsps_pkg::FSPS_IDLE;
                        nxt_s.stalled = 1'b0;
                        nxt_s.resume  = 1'b1;
                    end else if (last_addr) begin
                        nxt_s.state   = fsps_pkg::FSPS_IDLE;
                        nxt_s.stalled = 1'b0;
                        nxt_s.resume  = 1'b1;
                    end else begin
                        nxt_s.fl_addr = {s_ff.aph, s_ff.fl_addr[7:0] + 8'h01};
                        nxt_s.state   = (s_ff.cmd == fsps_pkg::CMD_BLANK) ?
                                        fsps_pkg::FSPS_CHECK : fsps_pkg::FSPS_MODIFY;
                    end
                end
            end
            default: begin
                nxt_s.state   = fsps_pkg::FSPS_IDLE;
                nxt_s.fl_req  = 1'b0;
                nxt_s.stalled = 1'b0;
            end
        endcase

        // Errors are sticky; a set in the same cycle as a clear survives
        nxt_s.status = nxt_s.status | st_set;
        irq_set[fsps_pkg::IRQ_DONE] = nxt_s.resume;
        irq_set[fsps_pkg::IRQ_ERR]  = st_set[fsps_pkg::ST_VERIFY] | st_set[fsps_pkg::ST_PROTECT];
        irq_set[fsps_pkg::IRQ_MODE] = st_set[fsps_pkg::ST_MODE_ERR];
        nxt_s.irq_st = nxt_s.irq_st | irq_set;
        nxt_s.irq    = |(nxt_s.irq_st & nxt_s.irq_en);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    // Reset leaves flash mode off and the command register empty
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_ff          <= '0;
            s_ff.state    <= fsps_pkg::FSPS_IDLE;
            s_ff.cmd      <= fsps_pkg::RST_BYTE;
            s_ff.boundary <= fsps_pkg::RST_BOUNDARY;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // Outputs come straight from the state flip-flops
    assign prdata      = s_ff.prdata;
    assign pready      = s_ff.pready;
    assign pslverr     = s_ff.pslverr;
    assign cpu_resume  = s_ff.resume;
    assign cpu_stalled = s_ff.stalled;
    assign wdt_restart = s_ff.wdt;
    assign irq         = s_ff.irq;
    assign fl_req      = s_ff.fl_req;
    assign fl_op       = s_ff.fl_op;
    assign fl_addr     = s_ff.fl_addr;
    assign fl_wdata    = s_ff.fl_wdata;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_idle_resume: assert property (
        halt_go && !s_ff.mode_on |=> cpu_resume && !cpu_stalled ##1 !cpu_resume)
        else $error("halt outside flash mode did not resume at once");

    a_protect_flag: assert property (
        halt_go && s_ff.mode_on && s_ff.cmd == fsps_pkg::CMD_ERASE && prot_hit
        |=> s_ff.status[fsps_pkg::ST_PROTECT] && !fl_req && cpu_resume)
        else $error("protected erase not flagged");

    a_verify_flag: assert property (
        s_ff.state == fsps_pkg::FSPS_CHECK && fl_req && fl_ack
        && s_ff.cmd == fsps_pkg::CMD_BLANK && fl_rdata != fsps_pkg::ERASED_BYTE
        |=> s_ff.status[fsps_pkg::ST_VERIFY] && cpu_resume)
        else $error("blank check failure not flagged");

    a_error_sticky: assert property (
        s_ff.status[fsps_pkg::ST_VERIFY] && !(wr && paddr == fsps_pkg::OFF_STATUS)
        |=> s_ff.status[fsps_pkg::ST_VERIFY])
        else $error("verify error cleared without a status write");

    a_req_hold: assert property (
        fl_req && !fl_ack |=> fl_req && $stable(fl_addr) && $stable(fl_op))
        else $error("flash request dropped before acknowledge");

    a_prog_data: assert property (
        fl_req && fl_op == fsps_pkg::FSPS_OP_PROG
        |-> fl_wdata == s_ff.wbuf && s_ff.cmd == fsps_pkg::CMD_WRITE)
        else $error("program data differs from write buffer");

    a_write_addr: assert property (
        fl_req && fl_op == fsps_pkg::FSPS_OP_PROG |-> fl_addr == {s_ff.aph, s_ff.apl})
        else $error("byte write at wrong address");

    a_erase_op: assert property (
        s_ff.state == fsps_pkg::FSPS_MODIFY && fl_req && s_ff.cmd == fsps_pkg::CMD_ERASE
        |-> fl_op == fsps_pkg::FSPS_OP_ERASE && fl_addr[15:8] == s_ff.aph)
        else $error("erase command issued wrong flash operation");

    a_erase_sweep: assert property (
        s_ff.state == fsps_pkg::FSPS_CHECK && fl_req && fl_ack
        && s_ff.cmd == fsps_pkg::CMD_ERASE && fl_rdata == fsps_pkg::ERASED_BYTE
        && !(&fl_addr[7:0]) |=> cpu_stalled && !cpu_resume)
        else $error("block erase ended before the last cell");

    a_mode_error: assert property (
        wr && !s_ff.stalled && paddr == fsps_pkg::OFF_MODE && !s_ff.armed
        |=> s_ff.status[fsps_pkg::ST_MODE_ERR] && $stable(s_ff.mode_on))
        else $error("unkeyed mode write not flagged");

    a_status_clear: assert property (
        wr && !s_ff.stalled && paddr == fsps_pkg::OFF_STATUS && wb == 8'h00
        && s_ff.state == fsps_pkg::FSPS_IDLE && !cpu_halt_req && !s_ff.armed
        |=> s_ff.status == 3'h0)
        else $error("status not cleared by zero write");

endmodule

/* File: sim/fsps_flash_model.sv */
`timescale 1ns/1ns
module fsps_flash_model #(
    parameter logic [15:0] STUCK_ADDR = 16'h0910
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        fl_req,
    input  wire logic [1:0]  fl_op,
    input  wire logic [15:0] fl_addr,
    input  wire logic [7:0]  fl_wdata,
    input  wire logic [1:0]  lat,
    input  wire logic        stuck_en,
    output logic             fl_ack,
    output logic      [7:0]  fl_rdata
);
    logic [7:0] mem [0:65535];
    logic [1:0] wait_cnt;

    ////////////////////////////////////////
    // Answer after lat idle cycles; a program may only clear bits, like real cells
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            foreach (mem[i]) mem[i] <= 8'hFF;
            mem[16'h0540] <= 8'h00;
            mem[16'h0542] <= 8'h00;
            mem[16'h05FF] <= 8'h00;
            mem[16'h0300] <= 8'h3C;
            fl_ack <= 1'b0;
            wait_cnt <= 2'h0;
            fl_rdata <= 8'h5A;
        end else begin
            fl_ack <= 1'b0;
            fl_rdata <= ~fl_rdata; // Stale data flips so it never passes as valid
            if (fl_req && !fl_ack) begin
                if (wait_cnt < lat) begin
                    wait_cnt <= wait_cnt + 2'h1;
                end else begin
                    wait_cnt <= 2'h0;
                    fl_ack <= 1'b1;
                    case (fl_op)
                        fsps_pkg::FSPS_OP_READ: fl_rdata <= mem[fl_addr];
                        fsps_pkg::FSPS_OP_PROG: mem[fl_addr] <= mem[fl_addr] & fl_wdata;
                        default: mem[fl_addr] <= (stuck_en && fl_addr == STUCK_ADDR) ?
                                                 8'h00 : 8'hFF;
                    endcase
                end
            end
        end
    end
endmodule

/* File: sim/fsps_sequencer_tb_top.sv */
`timescale 1ns/1ns
module fsps_sequencer_tb_top;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        cpu_halt_req, cpu_resume, cpu_stalled, wdt_restart, irq;
    logic        fl_req, fl_ack, stuck_en, er;
    logic [1:0]  fl_op, lat;
    logic [7:0]  paddr, fl_wdata, fl_rdata, d, a;
    logic [15:0] fl_addr;
    logic [31:0] pwdata, prdata, seed, st, rv;
    int          num_errors, cmp_count, wdt_pulses, loads, tries;

    fsps_sequencer i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cpu_halt_req(cpu_halt_req), .cpu_resume(cpu_resume),
        .cpu_stalled(cpu_stalled), .wdt_restart(wdt_restart), .irq(irq), .fl_req(fl_req),
        .fl_op(fl_op), .fl_addr(fl_addr), .fl_wdata(fl_wdata), .fl_ack(fl_ack),
        .fl_rdata(fl_rdata));
    fsps_flash_model i_flash (.pclk(pclk), .presetn(presetn), .fl_req(fl_req),
        .fl_op(fl_op), .fl_addr(fl_addr), .fl_wdata(fl_wdata), .lat(lat),
        .stuck_en(stuck_en), .fl_ack(fl_ack), .fl_rdata(fl_rdata));

    ////////////////////////////////////////
    // Clock and restart pulse counting
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    always @(posedge pclk) if (wdt_restart === 1'b1) wdt_pulses++;

    ////////////////////////////////////////
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] ad, input logic [7:0] dt);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= {24'h0, dt};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1);
        rv = prdata;
        er = pslverr;
        check(n, 2);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
        apb(1'b1, ad, dt);
    endtask
    task automatic rdc(input logic [7:0] ad, input logic [31:0] exp);
        apb(1'b0, ad, 8'h00);
        check(rv, exp);
    endtask
    // Halt, wait for the resume pulse, then fetch the status
    task automatic go();
        int n;
        rv = xs();
        lat <= rv[1:0];
        cpu_halt_req <= 1'b1;
        @(posedge pclk);
        cpu_halt_req <= 1'b0;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
            if (n == 2 && cpu_resume !== 1'b1) check(cpu_stalled, 1'b1);
        end while (cpu_resume !== 1'b1 && n < 4000);
        check(n < 4000, 1);
        @(posedge pclk);
        check(cpu_stalled, 1'b0);
        apb(1'b0, fsps_pkg::OFF_STATUS, 8'h00);
        st = rv;
    endtask
    task automatic run(input logic [7:0] c, input logic [7:0] b, input logic [7:0] pl,
                       input logic [7:0] cl, input logic [7:0] wb);
        wr(fsps_pkg::OFF_CMD, c);
        wr(fsps_pkg::OFF_APH, b);
        wr(fsps_pkg::OFF_APL, pl);
        wr(fsps_pkg::OFF_ACH, b);
        wr(fsps_pkg::OFF_ACL, cl);
        wr(fsps_pkg::OFF_WBUF, wb);
        wr(fsps_pkg::OFF_STATUS, 8'h00);
        wr(fsps_pkg::OFF_WATCHDOG_ENABLE_REG, fsps_pkg::WDT_KEY);
        loads++;
        go();
    endtask

    ////////////////////////////////////////
    // Watchdog: the slowest run is near 3k cycles, so 40k cycles means a hang
    initial begin
        #400000;
        num_errors++;
        report_and_stop();
    end
    initial begin
        {psel, penable, pwrite, cpu_halt_req, stuck_en, presetn} = '0;
        {paddr, pwdata, lat} = '0;
        {num_errors, cmp_count, wdt_pulses, loads} = '0;
        seed = 32'h870E;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdc(fsps_pkg::OFF_STATUS, 32'h0);
        apb(1'b0, 8'h3C, 8'h00);
        check({31'h0, er}, 32'h1);
        check(rv, 32'h0);
        // Outside self-programming mode a command touches nothing
        run(fsps_pkg::CMD_ERASE, 8'h05, 8'h00, 8'h00, 8'h00);
        check(st, 32'h0);
        check({24'h0, i_flash.mem[16'h0540]}, 32'h0);
        // Broken key sequence, then the proper one
        wr(fsps_pkg::OFF_PCMD, fsps_pkg::PROTECT_KEY);
        wr(fsps_pkg::OFF_MODE, 8'h01);
        wr(fsps_pkg::OFF_MODE, 8'h01);
        rdc(fsps_pkg::OFF_STATUS, 32'h1);
        rdc(fsps_pkg::OFF_STATE, 32'h0);
        wr(fsps_pkg::OFF_PCMD, fsps_pkg::PROTECT_KEY);
        wr(fsps_pkg::OFF_MODE, 8'h01);
        wr(fsps_pkg::OFF_MODE, 8'hFE);
        wr(fsps_pkg::OFF_MODE, 8'h01);
        rdc(fsps_pkg::OFF_STATE, 32'h1);
        wr(fsps_pkg::OFF_IRQ_CLR, 8'h07);
        wr(fsps_pkg::OFF_IRQ_EN, 8'h07);
        // Whole clean block blanks; the block with old data does not
        run(fsps_pkg::CMD_BLANK, 8'h06, 8'h00, 8'hFF, 8'h00);
        check(st, 32'h0);
        rdc(fsps_pkg::OFF_IRQ_ST, 32'h1);
        check(irq, 1'b1);
        wr(fsps_pkg::OFF_IRQ_CLR, 8'h07);
        run(fsps_pkg::CMD_BLANK, 8'h05, 8'h00, 8'hFF, 8'h00);
        check(st, 32'h2);
        wr(fsps_pkg::OFF_IRQ_EN, 8'h00);
        rdc(fsps_pkg::OFF_IRQ_ST, 32'h3);
        check(irq, 1'b0);
        wr(fsps_pkg::OFF_IRQ_EN, 8'h07);
        wr(fsps_pkg::OFF_IRQ_CLR, 8'h07);
        rdc(fsps_pkg::OFF_IRQ_ST, 32'h0);
        check(irq, 1'b0);
        // Unknown code resumes, old flag left standing
        wr(fsps_pkg::OFF_CMD, 8'h07);
        go();
        check(st, 32'h2);
        // Block erase clears every cell, the last one of the block included
        run(fsps_pkg::CMD_ERASE, 8'h05, 8'h00, 8'h00, 8'h00);
        check(st, 32'h0);
        check({8'h0, i_flash.mem[16'h0540], i_flash.mem[16'h0542],
               i_flash.mem[16'h05FF]}, 32'hFFFFFF);
        // Byte write, then a rewrite that needs erasing first
        rv = xs();
        d = rv[7:0] & 8'hFE;
        a = rv[15:8];
        run(fsps_pkg::CMD_WRITE, 8'h07, a, 8'h00, d);
        check(st, 32'h0);
        check({24'h0, i_flash.mem[{8'h07, a}]}, {24'h0, d});
        run(fsps_pkg::CMD_WRITE, 8'h07, a, 8'h00, ~d);
        check(st, 32'h2);
        run(fsps_pkg::CMD_ERASE, 8'h07, 8'h00, 8'h00, 8'h00);
        run(fsps_pkg::CMD_WRITE, 8'h07, a, 8'h00, ~d);
        check(st, 32'h0);
        check({24'h0, i_flash.mem[{8'h07, a}]}, {24'h0, ~d});
        // Protected block refuses erase and write
        wr(fsps_pkg::OFF_BOUNDARY, 8'h08);
        run(fsps_pkg::CMD_ERASE, 8'h03, 8'h00, 8'h00, 8'h00);
        check(st, 32'h4);
        check({24'h0, i_flash.mem[16'h0300]}, 32'h3C);
        run(fsps_pkg::CMD_WRITE, 8'h03, 8'h01, 8'h00, 8'h12);
        check(st, 32'h4);
        check({24'h0, i_flash.mem[16'h0301]}, 32'hFF);
        // Software retries an erase that fails twice
        stuck_en <= 1'b1;
        tries = 0;
        do begin
            tries++;
            if (tries == 3) stuck_en <= 1'b0;
            run(fsps_pkg::CMD_ERASE, 8'h09, 8'h00, 8'h00, 8'h00);
        end while (st !== 32'h0 && tries < 48);
        check(tries, 3);
        check(wdt_pulses, loads);
        report_and_stop();
    end
endmodule
